//--- hw/scaler_pkg.sv
// package: constants and carriers for the analog gain/offset scaler
package scaler_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GAIN = 8'h04;
  localparam logic [7:0] OFF_OFFSET = 8'h08;
  localparam logic [7:0] OFF_INVERT = 8'h0c;
  localparam logic [7:0] OFF_RETAIN = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;
  localparam logic [7:0] OFF_RESULT = 8'h18;
  localparam logic [7:0] OFF_SFIN = 8'h1c;
  localparam logic [7:0] OFF_RETCAP = 8'h20;
  // widths
  localparam int ADC_W = 12;
  localparam int NUM_SF = 16;
  // count limits
  localparam logic [9:0] COUNT_MAX = 10'h3e8;
  localparam logic [ADC_W-1:0] ADC_FULL = 12'hfff;
  // gain in hundredths, limits -10.00 .. +10.00
  localparam logic signed [15:0] GAIN_MAX = 16'sh03e8;
  localparam logic signed [15:0] GAIN_MIN = -16'sh03e8;
  localparam logic signed [15:0] GAIN_SCALE = 16'sh0064;
  // offset limits -10000 .. +10000
  localparam logic signed [15:0] OFFSET_MAX = 16'sh2710;
  localparam logic signed [15:0] OFFSET_MIN = -16'sh2710;
  // reset values and retain-capable function mask
  localparam logic signed [15:0] GAIN_RST = 16'sh0064;
  localparam logic signed [15:0] OFFSET_RST = 16'sh0000;
  localparam logic [NUM_SF-1:0] RETCAP_DEF = 16'h00ff;
  // ctrl field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_OVR_BIT = 1;
  // pipeline state
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_MUL = 2'b01, ST_ADD = 2'b11} pipe_e;
  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  // apb answer carrier
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;
endpackage : scaler_pkg

//--- hw/sat_clamp.sv
// module: signed clamp of a value into an inclusive range
`timescale 1ns/1ps
`default_nettype none
module sat_clamp
(
  // value in
  input wire logic signed [31:0] val_i,
  // bounds
  input wire logic signed [31:0] lo_i,
  input wire logic signed [31:0] hi_i,
  // clamped value out
  output logic signed [31:0] val_o
);
  // clamp combinationally
  always_comb
  begin
    if (val_i > hi_i)
    begin
      val_o = hi_i;
    end
    else if (val_i < lo_i)
    begin
      val_o = lo_i;
    end
    else
    begin
      val_o = val_i;
    end
  end
endmodule : sat_clamp
`default_nettype wire

//--- hw/analog_gain_offset_scaler.sv
// module: analog count conversion, gain/offset scaling, sf input options
// Contract
// - map zero..full scale linearly onto 0..1000
// - saturate count at 1000 above full scale
// - result is count times gain plus offset
// - gain signed hundredths, -10.00 to +10.00
// - offset signed integer, -10000 to +10000
// - each special function input invertible individually
// - retention only for retain-capable functions
`timescale 1ns/1ps
`default_nettype none
module analog_gain_offset_scaler
  import scaler_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire scaler_pkg::apb_req_s apb_req,
  output scaler_pkg::apb_rsp_s apb_rsp,
  // converter sample, full scale at all ones, over-range flag
  input wire logic [scaler_pkg::ADC_W-1:0] analog_voltage_input,
  input wire logic analog_over_range,
  input wire logic sample_valid,
  // special function raw logical inputs
  input wire logic [scaler_pkg::NUM_SF-1:0] sf_raw_in,
  // outputs
  output logic signed [31:0] scaled_analog_channel,
  output logic scaled_valid,
  output logic [9:0] internal_count,
  output logic [scaler_pkg::NUM_SF-1:0] special_function_block,
  output logic [scaler_pkg::NUM_SF-1:0] sf_retain
);
  import scaler_pkg::*;

  // register state
  logic ctrl_en_q, ctrl_en_d;                 // scaling enable
  logic signed [15:0] gain_q, gain_d;         // gain, hundredths
  logic signed [15:0] offset_q, offset_d;     // offset, integer
  logic [NUM_SF-1:0] inv_q, inv_d;            // per input invert mask
  logic [NUM_SF-1:0] ret_q, ret_d;            // retention request mask
  logic [31:0] prdata_q, prdata_d;            // read data
  logic pslverr_q, pslverr_d;                 // error flag of answer
  logic ovr_q, ovr_d;                         // sticky over-range seen
  // input synchronisers for pin inputs
  logic [ADC_W-1:0] adc_s1_q, adc_s2_q;
  logic ovr_s1_q, ovr_s2_q, vld_s1_q, vld_s2_q;
  logic [NUM_SF-1:0] sf_s1_q, sf_s2_q;
  // pipeline
  pipe_e st_q, st_d;
  logic [9:0] count_q, count_d;
  logic signed [31:0] prod_q, prod_d;
  logic signed [31:0] res_q, res_d;
  logic res_vld_q, res_vld_d;
  logic [NUM_SF-1:0] sfo_q, sfo_d;
  // helpers
  logic acc, wr, setup;
  logic signed [31:0] gain_clamped, offset_clamped, wdata_s;
  logic [ADC_W+9:0] scaled_raw;

  // apb access strobes, zero wait state
  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite;
  assign setup = apb_req.psel & ~apb_req.penable; // setup phase of any transfer
  assign wdata_s = $signed(apb_req.pwdata);

  // clamp gain into -10.00..+10.00
  sat_clamp u_gain_clamp
  (
    .val_i(wdata_s),
    .lo_i(32'(GAIN_MIN)),
    .hi_i(32'(GAIN_MAX)),
    .val_o(gain_clamped)
  );

  // clamp offset into -10000..+10000
  sat_clamp u_offset_clamp
  (
    .val_i(wdata_s),
    .lo_i(32'(OFFSET_MIN)),
    .hi_i(32'(OFFSET_MAX)),
    .val_o(offset_clamped)
  );

  // two-flop synchronisers on all pin inputs
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      adc_s1_q <= '0;
      adc_s2_q <= '0;
      ovr_s1_q <= 1'b0;
      ovr_s2_q <= 1'b0;
      vld_s1_q <= 1'b0;
      vld_s2_q <= 1'b0;
      sf_s1_q <= '0;
      sf_s2_q <= '0;
    end
    else
    begin
      adc_s1_q <= analog_voltage_input;
      adc_s2_q <= adc_s1_q;
      ovr_s1_q <= analog_over_range;
      ovr_s2_q <= ovr_s1_q;
      vld_s1_q <= sample_valid;
      vld_s2_q <= vld_s1_q;
      sf_s1_q <= sf_raw_in;
      sf_s2_q <= sf_s1_q;
    end
  end

  // register file next values: read data and error at setup, writes at access
  always_comb
  begin
    ctrl_en_d = ctrl_en_q;
    gain_d = gain_q;
    offset_d = offset_q;
    inv_d = inv_q;
    ret_d = ret_q;
    // sticky over-range, set only by a delivered sample, not by idle line noise
    ovr_d = ovr_q | (ovr_s2_q & vld_s2_q);
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (wr)
    begin
      case (apb_req.paddr)
        OFF_CTRL:
        begin
          ctrl_en_d = apb_req.pwdata[CTRL_EN_BIT];
          // write one clears, a new over-range in the same cycle wins
          if (apb_req.pwdata[CTRL_OVR_BIT])
          begin
            ovr_d = ovr_s2_q & vld_s2_q;
          end
        end
        OFF_GAIN: gain_d = gain_clamped[15:0];
        OFF_OFFSET: offset_d = offset_clamped[15:0];
        OFF_INVERT: inv_d = apb_req.pwdata[NUM_SF-1:0];
        OFF_RETAIN: ret_d = apb_req.pwdata[NUM_SF-1:0] & RETCAP_DEF;
        default: ctrl_en_d = ctrl_en_q; // read only or unmapped: ignored
      endcase
    end
    if (setup)
    begin
      // captured in flops so that data and error stand through the access phase
      pslverr_d = 1'b0;
      case (apb_req.paddr)
        OFF_CTRL: prdata_d = {30'h0, ovr_q, ctrl_en_q};
        OFF_GAIN: prdata_d = 32'(gain_q);
        OFF_OFFSET: prdata_d = 32'(offset_q);
        OFF_INVERT: prdata_d = {16'h0, inv_q};
        OFF_RETAIN: prdata_d = {16'h0, ret_q};
        OFF_COUNT: prdata_d = {22'h0, count_q};
        OFF_RESULT: prdata_d = res_q;
        OFF_SFIN: prdata_d = {16'h0, sfo_q};
        OFF_RETCAP: prdata_d = {16'h0, RETCAP_DEF};
        default:
        begin
          prdata_d = 32'h0;
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  // register file flops
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_en_q <= 1'b1;
      gain_q <= GAIN_RST;
      offset_q <= OFFSET_RST;
      inv_q <= '0;
      ret_q <= '0;
      ovr_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      ctrl_en_q <= ctrl_en_d;
      gain_q <= gain_d;
      offset_q <= offset_d;
      inv_q <= inv_d;
      ret_q <= ret_d;
      ovr_q <= ovr_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // zero wait state answer; data and error come from the flops loaded at setup
  always_comb
  begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = pslverr_q & acc;
    apb_rsp.prdata = prdata_q;
  end

  // linear map of the sample to 0..1000
  assign scaled_raw = 22'(adc_s2_q) * 22'(COUNT_MAX);

  // scaling pipeline next values
  always_comb
  begin
    st_d = st_q;
    count_d = count_q;
    prod_d = prod_q;
    res_d = res_q;
    res_vld_d = 1'b0;
    sfo_d = sf_s2_q ^ inv_q;
    case (st_q)
      ST_IDLE:
      begin
        if (vld_s2_q && ctrl_en_q)
        begin
          if (ovr_s2_q)
          begin
            count_d = COUNT_MAX;
          end
          else
          begin
            count_d = 10'(scaled_raw / 22'(ADC_FULL));
          end
          st_d = ST_MUL;
        end
      end
      ST_MUL:
      begin
        // count times hundredths, then divide truncating toward zero
        prod_d = (32'($signed({1'b0, count_q})) * 32'(gain_q)) / 32'(GAIN_SCALE);
        st_d = ST_ADD;
      end
      ST_ADD:
      begin
        res_d = prod_q + 32'(offset_q);
        res_vld_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // scaling pipeline flops
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= ST_IDLE;
      count_q <= 10'h0;
      prod_q <= 32'h0;
      res_q <= 32'h0;
      res_vld_q <= 1'b0;
      sfo_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      count_q <= count_d;
      prod_q <= prod_d;
      res_q <= res_d;
      res_vld_q <= res_vld_d;
      sfo_q <= sfo_d;
    end
  end

  // outputs from flops
  assign scaled_analog_channel = res_q;
  assign scaled_valid = res_vld_q;
  assign internal_count = count_q;
  assign special_function_block = sfo_q;
  assign sf_retain = ret_q;
endmodule : analog_gain_offset_scaler
`default_nettype wire

//--- tb/scaler_chk.sv
// checker: port-level assertions for the scaler
`timescale 1ns/1ps
`default_nettype none
module scaler_chk
  import scaler_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // converter side
  input wire logic [scaler_pkg::ADC_W-1:0] analog_voltage_input,
  input wire logic analog_over_range,
  input wire logic sample_valid,
  // results
  input wire logic signed [31:0] scaled_analog_channel,
  input wire logic scaled_valid,
  input wire logic [9:0] internal_count,
  input wire logic [scaler_pkg::NUM_SF-1:0] sf_retain
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // pipeline gap after a result pulse
  sequence s_gap;
    !scaled_valid [*2];
  endsequence
  // steady over-range delivery
  sequence s_over;
    (sample_valid && analog_over_range) [*8];
  endsequence
  // steady full-scale code
  sequence s_full;
    (sample_valid && !analog_over_range && analog_voltage_input == ADC_FULL) [*8];
  endsequence
  // steady zero code
  sequence s_zero;
    (sample_valid && !analog_over_range && analog_voltage_input == '0) [*8];
  endsequence
  AST_COUNT_MAX: assert property (internal_count <= COUNT_MAX)
    else $error("count above full scale");
  AST_OVER_FULL: assert property (s_over |-> internal_count == COUNT_MAX)
    else $error("over-range did not give full count");
  AST_FULL_CODE: assert property (s_full |-> internal_count == COUNT_MAX)
    else $error("full-scale code did not give full count");
  AST_ZERO_CODE: assert property (s_zero |-> internal_count == 10'h000)
    else $error("zero code did not give zero count");
  AST_PULSE: assert property (scaled_valid |=> s_gap)
    else $error("result pulse too long");
  AST_HOLD: assert property ($changed(scaled_analog_channel) |-> scaled_valid)
    else $error("result moved without pulse");
  AST_RANGE: assert property (scaled_analog_channel >= -32'sh4e20 && scaled_analog_channel <= 32'sh4e20)
    else $error("result outside scaling range");
  AST_RETAIN: assert property ((sf_retain & ~RETCAP_DEF) == '0)
    else $error("retention on non-capable function");
endmodule : scaler_chk
bind analog_gain_offset_scaler scaler_chk scaler_chk_inst (.ref_clk, .sys_rst,
  .analog_voltage_input, .analog_over_range, .sample_valid, .scaled_analog_channel,
  .scaled_valid, .internal_count, .sf_retain);
`default_nettype wire

//--- tb/sensor_model.sv
// model: sensor and converter front end feeding the scaler
`timescale 1ns/1ps
`default_nettype none
module sensor_model
  import scaler_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // bench command: deliver code while go is high
  input wire logic go,
  input wire logic [scaler_pkg::ADC_W-1:0] code,
  input wire logic ovr,
  // converter side
  output logic [scaler_pkg::ADC_W-1:0] analog_voltage_input,
  output logic analog_over_range,
  output logic sample_valid
);
  // line state, quiet at start
  logic [ADC_W-1:0] code_q = '0;
  logic ovr_q = 1'b0;
  logic vld_q = 1'b0;
  // stale bus toggles while no sample is offered
  always @(posedge ref_clk)
  begin
    vld_q <= go;
    ovr_q <= go ? ovr : ~ovr_q;
    code_q <= go ? code : ~code_q;
  end
  // one driver per line
  assign sample_valid = vld_q;
  assign analog_over_range = ovr_q;
  assign analog_voltage_input = code_q;
endmodule : sensor_model
`default_nettype wire

//--- tb/analog_gain_offset_scaler_test.sv
// testbench: register and scaling tests of the scaler
`timescale 1ns/1ps
`default_nettype none
module analog_gain_offset_scaler_test;
  import scaler_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  apb_req_s apb_req = '0;
  apb_rsp_s apb_rsp;
  logic go = 1'b0;
  logic ovr = 1'b0;
  logic [ADC_W-1:0] code = '0;
  logic [ADC_W-1:0] ain;
  logic aovr, sval, svalid, err;
  logic [NUM_SF-1:0] sf_raw_in = '0;
  logic [NUM_SF-1:0] sf_out, sf_retain;
  logic signed [31:0] result;
  logic [9:0] count;
  logic [31:0] rd;
  int fails = 0;
  int samples_checked = 0;
  // code, over-range, gain in hundredths, offset
  int cases [8][4] = '{'{0, 0, 10, -30}, '{4095, 0, 10, -30}, '{2765, 0, 400, 1000},
    '{8, 0, 1, 0}, '{29, 0, -10, 0}, '{0, 1, 1000, -10000}, '{2048, 0, 2000, -20000},
    '{4095, 0, -1500, 2000}};
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  sensor_model sensor_model_inst (.ref_clk(ref_clk), .go(go), .code(code), .ovr(ovr),
    .analog_voltage_input(ain), .analog_over_range(aovr), .sample_valid(sval));
  analog_gain_offset_scaler analog_gain_offset_scaler_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .analog_voltage_input(ain),
    .analog_over_range(aovr), .sample_valid(sval), .sf_raw_in(sf_raw_in),
    .scaled_analog_channel(result), .scaled_valid(svalid), .internal_count(count),
    .special_function_block(sf_out), .sf_retain(sf_retain));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
      fails++;
    if (got !== exp)
      $display("FAIL %0t got %h expected %h", $time, got, exp);
  endtask : chk
  // one apb transfer, read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    @(posedge ref_clk);
    while (apb_rsp.pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 50)
      fails++;
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge ref_clk);
  endtask : apb
  // program gain and offset, hold one code on the line for several samples, check count and first result
  task automatic conv(input int c, input int o, input int g, input int f);
    int cnt, eg, ef, n;
    eg = g > 1000 ? 1000 : (g < -1000 ? -1000 : g);
    ef = f > 10000 ? 10000 : (f < -10000 ? -10000 : f);
    cnt = o ? 1000 : c * 1000 / 4095;
    apb(1'b1, OFF_GAIN, 32'(g));
    apb(1'b0, OFF_GAIN, '0);
    chk(rd, 32'(eg));
    apb(1'b1, OFF_OFFSET, 32'(f));
    apb(1'b0, OFF_OFFSET, '0);
    chk(rd, 32'(ef));
    code <= 12'(c);
    ovr <= 1'(o);
    go <= 1'b1;
    n = 0;
    do @(posedge ref_clk); while (svalid !== 1'b1 && ++n < 30);
    if (n == 30)
      fails++;
    chk(32'(count), 32'(cnt));
    chk(result, 32'(cnt * eg / 100 + ef));
    repeat (4) @(posedge ref_clk);
    go <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : conv
  // verdict and end of run
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, OFF_GAIN, '0);
    chk(32'(rd[15:0]), 32'h0000_0064);
    apb(1'b0, 8'h40, '0);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, OFF_RETAIN, 32'h0000_ffff);
    apb(1'b1, OFF_RETCAP, 32'h0000_0000);
    apb(1'b0, OFF_RETCAP, '0);
    chk(32'(rd[15:0]), 32'(RETCAP_DEF));
    apb(1'b0, OFF_RETAIN, '0);
    chk(32'(rd[15:0]), 32'(RETCAP_DEF));
    chk(32'(sf_retain), 32'(RETCAP_DEF));
    apb(1'b1, OFF_INVERT, 32'h0000_a5a5);
    sf_raw_in <= 16'h0ff0;
    repeat (6) @(posedge ref_clk);
    chk(32'(sf_out), 32'(16'h0ff0 ^ 16'ha5a5));
    $display("register tests done");
    for (int i = 0; i < 8; i++)
      conv(cases[i][0], cases[i][1], cases[i][2], cases[i][3]);
    $display("scaling tests done");
    // sticky over-range from the over-range case, then clear it and disable scaling
    apb(1'b0, OFF_CTRL, '0);
    chk(rd, 32'h0000_0003);
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    apb(1'b0, OFF_CTRL, '0);
    chk(rd, 32'h0000_0000);
    // samples while disabled leave count and result of the last case
    code <= 12'h800;
    go <= 1'b1;
    repeat (12) @(posedge ref_clk);
    go <= 1'b0;
    chk(32'(count), 32'(COUNT_MAX));
    chk(result, 32'hffff_e0c0);
    apb(1'b0, OFF_COUNT, '0);
    chk(rd, 32'(COUNT_MAX));
    apb(1'b0, OFF_RESULT, '0);
    chk(rd, 32'hffff_e0c0);
    apb(1'b0, OFF_SFIN, '0);
    chk(rd, 32'(16'h0ff0 ^ 16'ha5a5));
    $display("control tests done");
    end_sim();
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_sim();
  end
endmodule : analog_gain_offset_scaler_test
`default_nettype wire
